// >>> design/rcp_clock_control.sv
// Reference clock source selection and PLL start control with register port
// How it works
// - Value 32 selects external PLL reference
// - Value 64 selects backplane PLL reference
// - Backplane reference fixed at 100 MHz
// - External mode derives sampling clock via PLL
// - PLL always used, no direct bypass
// - Unreachable rates accepted, nearest reported
// - Start loads settings, relocks only on change or when not locked
// - Start waits for lock, up to 200 ms
// - Lock failure makes start report lock error
// - Output enable drives clock, else tristate
// - Read-only output clock frequency value
// - Sample rate reads back achievable value
`timescale 1ns/1ps
module rcp_clock_control
#(
	parameter int LOCK_TIMEOUT = rcp_pkg::LOCK_TIMEOUT_CYCLES
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [31:0] i_reg_index,
	input wire logic [31:0] i_reg_wdata,
	output logic [31:0] o_reg_rdata,
	// Start answer
	output logic o_start_done,
	output logic o_lock_failure_error,
	// PLL control
	output logic [1:0] o_pll_ref_sel,
	output logic [7:0] o_pll_mult,
	output logic [7:0] o_pll_div,
	output logic o_pll_program,
	input wire logic i_pll_locked,
	// Clock output connector
	input wire logic i_sample_clk,
	output logic o_clock_out,
	output logic o_clock_out_oe
);
	// Controller state
	typedef struct packed
	{
		rcp_pkg::rcp_state_type st;
		logic [31:0] source;
		logic [31:0] ref_hz;
		logic [31:0] want_hz;
		logic out_en;
		logic dirty;
		logic locked;
		logic lock_err;
		logic [31:0] cnt;
		logic [1:0] ref_sel;
		logic [7:0] mult;
		logic [7:0] div;
		logic [31:0] out_hz;
		logic pll_load; // One-cycle strobe that loads new PLL settings
		logic done;
		logic lk_sync1;
		logic lk_sync2;
		logic [31:0] rdata;
	} rcp_ctrl_type;

	rcp_ctrl_type r;
	rcp_ctrl_type next_r;
	logic solve_go;
	logic solve_busy;
	logic [31:0] solve_rate;
	logic [7:0] solve_mult;
	logic [7:0] solve_div;
	logic [31:0] eff_ref;

	// Decode a register index
	function automatic logic is_reg(input logic [31:0] idx, input logic [31:0] which);
		is_reg = (idx == which);
	endfunction

	// Reference in use for the selected source
	always_comb
	begin
		if (r.source == rcp_pkg::BACKPLANE_REFERENCE_MODE)
			eff_ref = rcp_pkg::BACKPLANE_REFERENCE_HZ;
		else
			eff_ref = r.ref_hz;
	end

	// Recompute best rate whenever clock settings are written
	assign solve_go = i_reg_wr && (is_reg(i_reg_index, rcp_pkg::REG_CLOCK_SOURCE_SELECT)
		|| is_reg(i_reg_index, rcp_pkg::REG_REFERENCE_FREQUENCY)
		|| is_reg(i_reg_index, rcp_pkg::REG_SAMPLE_RATE_SETTING));

	rcp_rate_solver u_solver
	(
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_go(solve_go),
		.i_ref_hz(eff_ref),
		.i_want_hz(r.want_hz),
		.o_busy(solve_busy),
		.o_rate_hz(solve_rate),
		.o_mult(solve_mult),
		.o_div(solve_div)
	);

	// Register writes, reads and start sequence
	always_comb
	begin
		next_r = r;
		next_r.pll_load = 1'b0;
		next_r.done = 1'b0;
		next_r.lk_sync1 = i_pll_locked;
		next_r.lk_sync2 = r.lk_sync1;
		// Register writes; source, reference and rate writes mark clock settings as changed
		if (i_reg_wr)
		begin
			if (is_reg(i_reg_index, rcp_pkg::REG_CLOCK_SOURCE_SELECT))
			begin
				next_r.source = i_reg_wdata;
				next_r.dirty = 1'b1;
			end
			if (is_reg(i_reg_index, rcp_pkg::REG_REFERENCE_FREQUENCY))
			begin
				next_r.ref_hz = i_reg_wdata;
				next_r.dirty = 1'b1;
			end
			if (is_reg(i_reg_index, rcp_pkg::REG_SAMPLE_RATE_SETTING))
			begin
				next_r.want_hz = i_reg_wdata;
				next_r.dirty = 1'b1;
			end
			if (is_reg(i_reg_index, rcp_pkg::REG_CLOCK_OUTPUT_ENABLE))
				next_r.out_en = i_reg_wdata[0];
		end
		// Read mux, data from flip-flop
		if (i_reg_rd)
		begin
			if (is_reg(i_reg_index, rcp_pkg::REG_CLOCK_SOURCE_SELECT))
				next_r.rdata = r.source;
			else if (is_reg(i_reg_index, rcp_pkg::REG_REFERENCE_FREQUENCY))
				next_r.rdata = r.ref_hz;
			else if (is_reg(i_reg_index, rcp_pkg::REG_SAMPLE_RATE_SETTING))
				next_r.rdata = solve_rate;
			else if (is_reg(i_reg_index, rcp_pkg::REG_CLOCK_OUTPUT_ENABLE))
				next_r.rdata = {31'h0, r.out_en};
			else if (is_reg(i_reg_index, rcp_pkg::REG_CLOCK_OUTPUT_FREQUENCY))
				next_r.rdata = r.out_hz;
			else if (is_reg(i_reg_index, rcp_pkg::REG_CLOCK_STATUS))
				next_r.rdata = {29'h0, r.st != rcp_pkg::ST_IDLE, r.lock_err, r.locked};
			else
				next_r.rdata = 32'h0000_0000;
		end
		// Start sequencer
		case (r.st)
			rcp_pkg::ST_IDLE:
			begin
				if (i_reg_wr && is_reg(i_reg_index, rcp_pkg::REG_CARD_COMMAND)
					&& i_reg_wdata[rcp_pkg::CARD_START_BIT])
					next_r.st = rcp_pkg::ST_LOAD;
			end
			rcp_pkg::ST_LOAD:
			begin
				// Wait for best rate search, then load into PLL if settings changed or not locked
				if (!solve_busy)
				begin
					if (r.dirty || !r.locked)
					begin
						if (r.source == rcp_pkg::EXTERNAL_REFERENCE_MODE)
							next_r.ref_sel = 2'h1;
						else if (r.source == rcp_pkg::BACKPLANE_REFERENCE_MODE)
							next_r.ref_sel = 2'h2;
						else
							next_r.ref_sel = 2'h0;
						next_r.mult = solve_mult;
						next_r.div = solve_div;
						next_r.pll_load = 1'b1;
						next_r.locked = 1'b0;
						next_r.lock_err = 1'b0;
						next_r.dirty = 1'b0;
						next_r.cnt = 32'h0000_0000;
						next_r.st = rcp_pkg::ST_WAIT_LOCK;
					end
					else
						next_r.st = rcp_pkg::ST_DONE;
				end
			end
			rcp_pkg::ST_WAIT_LOCK:
			begin
				// Wait for lock, bounded by the longest lock time
				next_r.cnt = r.cnt + 32'h0000_0001;
				if (r.lk_sync2)
				begin
					next_r.cnt = 32'h0000_0000;
					next_r.st = rcp_pkg::ST_SETTLE;
				end
				else if (r.cnt >= LOCK_TIMEOUT - 1)
				begin
					next_r.lock_err = 1'b1;
					next_r.st = rcp_pkg::ST_DONE;
				end
			end
			rcp_pkg::ST_SETTLE:
			begin
				// Lock must hold continuously before it counts
				next_r.cnt = r.cnt + 32'h0000_0001;
				if (!r.lk_sync2)
					next_r.st = rcp_pkg::ST_WAIT_LOCK;
				else if (r.cnt >= rcp_pkg::SETTLE_CYCLES - 1)
				begin
					next_r.locked = 1'b1;
					next_r.out_hz = solve_rate;
					next_r.st = rcp_pkg::ST_DONE;
				end
			end
			rcp_pkg::ST_DONE:
			begin
				next_r.done = 1'b1;
				next_r.st = rcp_pkg::ST_IDLE;
			end
			default:
				next_r.st = rcp_pkg::ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			r <= '{st: rcp_pkg::ST_IDLE, source: 32'h0000_0000, ref_hz: 32'h0000_0000, want_hz: 32'h0000_0000,
				out_en: 1'b0, dirty: 1'b1, locked: 1'b0, lock_err: 1'b0, cnt: 32'h0000_0000,
				ref_sel: 2'h0, mult: 8'h01, div: 8'h01, out_hz: 32'h0000_0000, pll_load: 1'b0,
				done: 1'b0, lk_sync1: 1'b0, lk_sync2: 1'b0, rdata: 32'h0000_0000};
		else
			r <= next_r;
	end

	// Outputs
	assign o_reg_rdata = r.rdata;
	assign o_start_done = r.done;
	assign o_lock_failure_error = r.done & r.lock_err;
	assign o_pll_ref_sel = r.ref_sel;
	assign o_pll_mult = r.mult;
	assign o_pll_div = r.div;
	assign o_pll_program = r.pll_load;
	assign o_clock_out = i_sample_clk & r.out_en;
	assign o_clock_out_oe = r.out_en;
endmodule

// >>> design/rcp_pkg.sv
// Package with register indices, modes and timing constants for the reference clock PLL control
package rcp_pkg;
	// Register indices as printed
	localparam logic [31:0] REG_CLOCK_OUTPUT_ENABLE = 32'h0000_4e8e;
	localparam logic [31:0] REG_CLOCK_OUTPUT_FREQUENCY = 32'h0000_4e8f;
	localparam logic [31:0] REG_REFERENCE_FREQUENCY = 32'h0000_4eac;
	localparam logic [31:0] REG_CLOCK_SOURCE_SELECT = 32'h0000_4ee8;
	localparam logic [31:0] REG_SAMPLE_RATE_SETTING = 32'h0000_4e20;
	localparam logic [31:0] REG_CARD_COMMAND = 32'h0000_4e21;
	localparam logic [31:0] REG_CLOCK_STATUS = 32'h0000_4e22;
	// Clock source codes
	localparam logic [31:0] EXTERNAL_REFERENCE_MODE = 32'h0000_0020;
	localparam logic [31:0] BACKPLANE_REFERENCE_MODE = 32'h0000_0040;
	// Card start command bit
	localparam int CARD_START_BIT = 2;
	// Status bit positions
	localparam int STAT_LOCKED_BIT = 0;
	localparam int STAT_ERROR_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;
	// Fixed backplane reference in Hz
	localparam logic [31:0] BACKPLANE_REFERENCE_HZ = 32'd100_000_000;
	// PLL synthesis limits in Hz
	localparam logic [31:0] VCO_MIN_HZ = 32'd20_000_000;
	localparam logic [31:0] VCO_MAX_HZ = 32'd500_000_000;
	localparam logic [7:0] MULT_MAX = 8'h20;
	localparam logic [7:0] DIV_MAX = 8'h20;
	// Lock wait time
	localparam int CLOCK_HZ = 40_000_000;
	localparam int LOCK_TIMEOUT_MS = 200;
	localparam int LOCK_TIMEOUT_CYCLES = LOCK_TIMEOUT_MS * (CLOCK_HZ / 1000);
	localparam int SETTLE_US = 100;
	localparam int SETTLE_CYCLES = SETTLE_US * (CLOCK_HZ / 1_000_000);
	// Controller states
	typedef enum logic [2:0] {ST_IDLE, ST_LOAD, ST_WAIT_LOCK, ST_SETTLE, ST_DONE} rcp_state_type;
endpackage

// >>> design/rcp_rate_solver.sv
// Best achievable sample rate search over multiplier and divider pairs
`timescale 1ns/1ps
module rcp_rate_solver
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Request
	input wire logic i_go,
	input wire logic [31:0] i_ref_hz,
	input wire logic [31:0] i_want_hz,
	// Result
	output logic o_busy,
	output logic [31:0] o_rate_hz,
	output logic [7:0] o_mult,
	output logic [7:0] o_div
);
	// Solver state
	typedef struct packed
	{
		logic busy;
		logic [7:0] m;
		logic [7:0] d;
		logic [31:0] best_err;
		logic [31:0] rate;
		logic [7:0] bm;
		logic [7:0] bd;
	} rcp_solver_type;

	rcp_solver_type r;
	rcp_solver_type next_r;
	logic [39:0] vco;
	logic [39:0] cand;
	logic [31:0] err;

	// Candidate rate for current pair
	always_comb
	begin
		vco = {8'h00, i_ref_hz} * {32'h0000_0000, r.m};
		cand = vco / {32'h0000_0000, r.d};
		err = (cand[31:0] > i_want_hz) ? cand[31:0] - i_want_hz : i_want_hz - cand[31:0];
	end

	// Walk all pairs keeping the closest legal one
	always_comb
	begin
		next_r = r;
		if (i_go)
		begin
			next_r.busy = 1'b1;
			next_r.m = 8'h01;
			next_r.d = 8'h01;
			next_r.best_err = 32'hffff_ffff;
		end
		else if (r.busy)
		begin
			// VCO must stay in range; unreachable rates fall back to nearest
			if (vco >= {8'h00, rcp_pkg::VCO_MIN_HZ} && vco <= {8'h00, rcp_pkg::VCO_MAX_HZ}
				&& cand[39:32] == 8'h00 && err < r.best_err)
			begin
				next_r.best_err = err;
				next_r.rate = cand[31:0];
				next_r.bm = r.m;
				next_r.bd = r.d;
			end
			if (r.d == rcp_pkg::DIV_MAX)
			begin
				next_r.d = 8'h01;
				if (r.m == rcp_pkg::MULT_MAX)
					next_r.busy = 1'b0;
				else
					next_r.m = r.m + 8'h01;
			end
			else
				next_r.d = r.d + 8'h01;
		end
	end

	// State register
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			r <= '{busy: 1'b0, m: 8'h01, d: 8'h01, best_err: 32'hffff_ffff, rate: 32'h0000_0000,
				bm: 8'h01, bd: 8'h01};
		else
			r <= next_r;
	end

	// Outputs
	assign o_busy = r.busy | i_go;
	assign o_rate_hz = r.rate;
	assign o_mult = r.bm;
	assign o_div = r.bd;
endmodule

// >>> test/rcp_clock_control_bench.sv
// Self-checking bench for the clock control
`timescale 1ns/1ps
module rcp_clock_control_bench;
	logic i_clk, i_rst_n, i_reg_wr, i_reg_rd, i_pll_locked, i_sample_clk, ref_ok;
	logic [31:0] i_reg_index, i_reg_wdata, o_reg_rdata, rd_val;
	logic o_start_done, o_lock_failure_error, o_pll_program, o_clock_out, o_clock_out_oe;
	logic [1:0] o_pll_ref_sel;
	logic [7:0] o_pll_mult, o_pll_div;
	int bad_count, tests_run, prog_n, cyc, n, hi;
	// Design with a short lock timeout
	rcp_clock_control #(.LOCK_TIMEOUT(200)) dut (.i_clk, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_index,
		.i_reg_wdata, .o_reg_rdata, .o_start_done, .o_lock_failure_error, .o_pll_ref_sel, .o_pll_mult,
		.o_pll_div, .o_pll_program, .i_pll_locked, .i_sample_clk, .o_clock_out, .o_clock_out_oe);
	rcp_pll_model pll (.i_clk, .i_rst_n, .i_ref_ok(ref_ok), .i_pll_ref_sel(o_pll_ref_sel),
		.i_pll_program(o_pll_program), .o_pll_locked(i_pll_locked), .o_sample_clk(i_sample_clk));
	// 40 MHz clock
	initial
	begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// Count programming pulses and cut a hang short
	always @(posedge i_clk)
	begin
		cyc++;
		if (o_pll_program === 1'b1) prog_n++;
		if (cyc == 60000)
		begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) bad_count++;
		if (got !== exp) $display("[FAIL] %s expected %h seen %h", what, exp, got);
	endtask
	task automatic wr(input logic [31:0] idx, input logic [31:0] d);
		@(posedge i_clk);
		i_reg_wr <= 1'b1;
		i_reg_index <= idx;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask
	// Read and compare one register
	task automatic rchk(input string what, input logic [31:0] idx, input logic [31:0] exp);
		@(posedge i_clk);
		i_reg_rd <= 1'b1;
		i_reg_index <= idx;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		@(posedge i_clk);
		rd_val = o_reg_rdata;
		chk(what, exp, rd_val);
	endtask
	// Issue start and wait for its answer
	task automatic start(input logic exp_err);
		logic seen;
		seen = 1'b0;
		wr(rcp_pkg::REG_CARD_COMMAND, 32'h1 << rcp_pkg::CARD_START_BIT);
		for (int i = 0; i < 6000 && !seen; i++)
		begin
			@(posedge i_clk);
			#1;
			seen = (o_start_done === 1'b1);
		end
		chk("start done", 32'h1, {31'h0, seen});
		chk("lock error", {31'h0, exp_err}, {31'h0, o_lock_failure_error});
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		{i_rst_n, i_reg_wr, i_reg_rd, i_reg_index, i_reg_wdata} = '0;
		ref_ok = 1'b1;
		repeat (20) @(posedge i_clk);
		chk("oe reset", 32'h0, {31'h0, o_clock_out_oe});
		chk("ratio reset", 32'h0101, {16'h0, o_pll_mult, o_pll_div});
		i_rst_n <= 1'b1;
		wr(rcp_pkg::REG_CLOCK_SOURCE_SELECT, rcp_pkg::EXTERNAL_REFERENCE_MODE);
		wr(rcp_pkg::REG_REFERENCE_FREQUENCY, 32'd20_000_000);
		wr(rcp_pkg::REG_SAMPLE_RATE_SETTING, 32'd100_000_000);
		start(1'b0);
		chk("ext select", 32'h1, {30'h0, o_pll_ref_sel});
		rchk("rate", rcp_pkg::REG_SAMPLE_RATE_SETTING, 32'd100_000_000);
		rchk("out freq", rcp_pkg::REG_CLOCK_OUTPUT_FREQUENCY, 32'd100_000_000);
		rchk("status", rcp_pkg::REG_CLOCK_STATUS, 32'h1);
		n = prog_n;
		start(1'b0);
		chk("no relock", n, prog_n);
		$display("test external done");
		wr(rcp_pkg::REG_SAMPLE_RATE_SETTING, 32'd20_000_000);
		start(1'b0);
		chk("relock", n + 1, prog_n);
		chk("copy ratio", {24'h0, o_pll_mult}, {24'h0, o_pll_div});
		rchk("copy rate", rcp_pkg::REG_SAMPLE_RATE_SETTING, 32'd20_000_000);
		$display("test copy done");
		wr(rcp_pkg::REG_CLOCK_SOURCE_SELECT, rcp_pkg::BACKPLANE_REFERENCE_MODE);
		wr(rcp_pkg::REG_REFERENCE_FREQUENCY, 32'd7_000_000);
		wr(rcp_pkg::REG_SAMPLE_RATE_SETTING, 32'd50_000_000);
		start(1'b0);
		chk("bp select", 32'h2, {30'h0, o_pll_ref_sel});
		rchk("bp rate", rcp_pkg::REG_SAMPLE_RATE_SETTING, 32'd50_000_000);
		$display("test backplane done");
		wr(rcp_pkg::REG_CLOCK_OUTPUT_ENABLE, 32'h1);
		#1;
		chk("oe on", 32'h1, {31'h0, o_clock_out_oe});
		// Locked sampling clock must reach the connector
		hi = 0;
		repeat (8)
		begin
			@(posedge i_clk);
			if (o_clock_out === 1'b1) hi++;
		end
		chk("clock out on", 32'h1, {31'h0, hi != 0});
		wr(rcp_pkg::REG_CLOCK_OUTPUT_ENABLE, 32'h0);
		#1;
		chk("oe off", 32'h0, {31'h0, o_clock_out_oe});
		// Disabled output must stay quiet
		hi = 0;
		repeat (8)
		begin
			@(posedge i_clk);
			if (o_clock_out !== 1'b0) hi++;
		end
		chk("clock out off", 32'h0, hi);
		rchk("unmapped", 32'h0000_4e90, 32'h0);
		$display("test clock out done");
		ref_ok <= 1'b0;
		wr(rcp_pkg::REG_SAMPLE_RATE_SETTING, 32'd100_000_000);
		start(1'b1);
		rchk("fail status", rcp_pkg::REG_CLOCK_STATUS, 32'h2);
		$display("test missing reference done");
		report_and_stop();
	end
endmodule

// >>> test/rcp_clock_control_properties.sv
// Port timing checker for the clock control
`timescale 1ns/1ps
module rcp_clock_control_checker
#(
	parameter int LOCK_TIMEOUT = 200
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [31:0] i_reg_index,
	input wire logic [31:0] i_reg_wdata,
	input wire logic [31:0] o_reg_rdata,
	// Start, PLL and output
	input wire logic o_start_done,
	input wire logic o_lock_failure_error,
	input wire logic [1:0] o_pll_ref_sel,
	input wire logic o_pll_program,
	input wire logic i_pll_locked,
	input wire logic i_sample_clk,
	input wire logic o_clock_out,
	input wire logic o_clock_out_oe
);
	logic [1:0] want_sel; // Source code last written
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Track the written source as a select code
	always_ff @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n) want_sel <= 2'h0;
		else if (i_reg_wr && i_reg_index == rcp_pkg::REG_CLOCK_SOURCE_SELECT)
			want_sel <= (i_reg_wdata == rcp_pkg::EXTERNAL_REFERENCE_MODE) ? 2'h1
				: (i_reg_wdata == rcp_pkg::BACKPLANE_REFERENCE_MODE) ? 2'h2 : 2'h0;
	property p_sel; o_pll_program |-> o_pll_ref_sel == want_sel; endproperty
	a_sel: assert property (p_sel) else $error("select differs");
	property p_sel_hold; $changed(o_pll_ref_sel) |-> o_pll_program; endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("select moved");
	property p_oe; i_reg_wr && i_reg_index == rcp_pkg::REG_CLOCK_OUTPUT_ENABLE
		|=> o_clock_out_oe == $past(i_reg_wdata[0]); endproperty
	a_oe: assert property (p_oe) else $error("enable wrong");
	property p_gate; o_clock_out == (i_sample_clk & o_clock_out_oe); endproperty
	a_gate: assert property (p_gate) else $error("clock gate wrong");
	property p_err; o_lock_failure_error |-> o_start_done && $past(!i_pll_locked, 3); endproperty
	a_err: assert property (p_err) else $error("error without done");
	property p_done; o_start_done && !o_lock_failure_error |-> $past(i_pll_locked, 3); endproperty
	a_done: assert property (p_done) else $error("done unlocked");
	property p_pulse; o_start_done |=> !o_start_done; endproperty
	a_pulse: assert property (p_pulse) else $error("done too long");
	property p_prog; o_pll_program |-> !o_start_done [*4]; endproperty
	a_prog: assert property (p_prog) else $error("done during load");
	property p_unmap; i_reg_rd && i_reg_index == 32'h0000_4e90 |=> o_reg_rdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped nonzero");
endmodule
bind rcp_clock_control rcp_clock_control_checker #(.LOCK_TIMEOUT(LOCK_TIMEOUT)) u_chk (.i_clk, .i_rst_n,
	.i_reg_wr, .i_reg_rd, .i_reg_index, .i_reg_wdata, .o_reg_rdata, .o_start_done, .o_lock_failure_error,
	.o_pll_ref_sel, .o_pll_program, .i_pll_locked, .i_sample_clk, .o_clock_out, .o_clock_out_oe);

// >>> test/rcp_pll_model.sv
// Behavioural PLL with its reference source
`timescale 1ns/1ps
module rcp_pll_model
#(
	parameter int LOCK_DELAY = 40
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Reference present
	input wire logic i_ref_ok,
	// PLL control
	input wire logic [1:0] i_pll_ref_sel,
	input wire logic i_pll_program,
	output logic o_pll_locked,
	output logic o_sample_clk
);
	int cnt; // Cycles since programming
	// Relock after programming, only with a reference
	always_ff @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n) cnt <= 0;
		else if (i_pll_program || !i_ref_ok || i_pll_ref_sel == 2'h0) cnt <= 0;
		else if (cnt < LOCK_DELAY) cnt <= cnt + 1;
	assign o_pll_locked = (cnt == LOCK_DELAY);
	// Sampling clock stands low while unlocked
	always_ff @(posedge i_clk or negedge i_rst_n)
		if (!i_rst_n) o_sample_clk <= 1'b0;
		else o_sample_clk <= o_pll_locked & ~o_sample_clk;
endmodule
